// ===== core/dtg_buf.sv
// two-entry valid/ready buffer for generated sample pairs
// assumes both sides on clk_sys; out_ready may stall indefinitely
`timescale 1ns/1ps
module dtg_buf #(
    parameter int unsigned WIDTH = 48,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    rd_q, rd_d, wr_q, wr_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] i);
        return (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
    endfunction : wrap_inc

    always_comb begin
        mem_d = mem_q;
        rd_d  = rd_q;
        wr_d  = wr_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d        = wrap_inc(wr_q);
        end
        if (pop) begin
            rd_d = wrap_inc(rd_q);
        end
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
            wr_q  <= wr_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : dtg_buf

// ===== core/dtg_top.sv
// dual tone generator: two 1 kHz sine or dc channels at a programmable sample rate
// assumes register port, rate input and consumers all run on clk_sys
`timescale 1ns/1ps

module dtg_top (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // register port
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [15:0]                 reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    output      logic [31:0]                 reg_rdata,
    // sample rate in hertz
    input  wire logic [dtg_pkg::RATE_W-1:0]  tone_rate_hz,
    // sample pair stream
    output      logic                        pair_valid,
    input  wire logic                        pair_ready,
    output      dtg_pkg::dtg_pair_type       pair_data,
    // one consumer source port
    input  wire logic [8:0]                  consumer_source_select,
    output      logic [23:0]                 consumer_sample
);
    import dtg_pkg::*;

    // register file
    logic [31:0]  ctrl_q, ctrl_d;
    logic [23:0]  first_gen_dc_level_q, first_gen_dc_level_d;
    logic [23:0]  second_gen_dc_level_q, second_gen_dc_level_d;
    logic [31:0]  rdata_q, rdata_d;

    logic         first_gen_enable, second_gen_enable;
    logic         first_gen_dc_select, second_gen_dc_select;
    logic [1:0]   phase_offset;

    assign first_gen_enable     = ctrl_q[BIT_EN1];
    assign second_gen_enable    = ctrl_q[BIT_EN2];
    assign first_gen_dc_select  = ctrl_q[BIT_DC1];
    assign second_gen_dc_select = ctrl_q[BIT_DC2];
    assign phase_offset         = ctrl_q[POS_OFFSET +: W_OFFSET];

    always_comb begin
        ctrl_d                = ctrl_q;
        first_gen_dc_level_d  = first_gen_dc_level_q;
        second_gen_dc_level_d = second_gen_dc_level_q;
        rdata_d               = rdata_q;
        if (reg_wr_en) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    // only documented bits are kept, the rest read zero
                    ctrl_d = '0;
                    ctrl_d[BIT_EN1]                 = reg_wdata[BIT_EN1];
                    ctrl_d[BIT_EN2]                 = reg_wdata[BIT_EN2];
                    ctrl_d[BIT_DC1]                 = reg_wdata[BIT_DC1];
                    ctrl_d[BIT_DC2]                 = reg_wdata[BIT_DC2];
                    ctrl_d[POS_OFFSET +: W_OFFSET]  = reg_wdata[POS_OFFSET +: W_OFFSET];
                end
                ADDR_LVL1: first_gen_dc_level_d  = reg_wdata[23:0];
                ADDR_LVL2: second_gen_dc_level_d = reg_wdata[23:0];
                default: ;
            endcase
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                ADDR_CTRL: rdata_d = ctrl_q;
                ADDR_LVL1: rdata_d = {8'h00, first_gen_dc_level_q};
                ADDR_LVL2: rdata_d = {8'h00, second_gen_dc_level_q};
                default:   rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q                <= CTRL_RESET;
            first_gen_dc_level_q  <= LVL_RESET;
            second_gen_dc_level_q <= LVL_RESET;
            rdata_q               <= 32'h0000_0000;
        end else begin
            ctrl_q                <= ctrl_d;
            first_gen_dc_level_q  <= first_gen_dc_level_d;
            second_gen_dc_level_q <= second_gen_dc_level_d;
            rdata_q               <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // fractional sample tick: adds the rate each clock, ticks on wrap of the clock rate
    // non-integer ratios (44.1k on 20 MHz) give jitter of one clock, not drift
    logic [24:0]  rate_acc_q, rate_acc_d;
    logic         tick_pend_q, tick_pend_d;
    logic [PH_W-1:0] phase_q, phase_d;
    logic [PH_W-1:0] phase_inc;
    logic         push_ready;
    logic         push;

    localparam logic [24:0] CLK_HZ_W = 25'(CLK_HZ);

    // increment = 2^32 * 1000 / rate; recomputed live so a rate change takes effect at once
    assign phase_inc = (tone_rate_hz == '0) ? '0
                     : PH_W'((64'(TONE_HZ) << PH_W) / 64'(tone_rate_hz));

    assign push = tick_pend_q && push_ready;

    always_comb begin
        rate_acc_d  = 25'(rate_acc_q + 25'(tone_rate_hz));
        tick_pend_d = tick_pend_q;
        phase_d     = phase_q;
        if (rate_acc_d >= CLK_HZ_W) begin
            rate_acc_d  = 25'(rate_acc_d - CLK_HZ_W);
            tick_pend_d = 1'b1;
        end
        // a sample waits while the buffer is full, so a stall drops no word
        if (push) begin
            phase_d = PH_W'(phase_q + phase_inc);
            if (rate_acc_d < CLK_HZ_W && !(rate_acc_q + 25'(tone_rate_hz) >= CLK_HZ_W)) begin
                tick_pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_acc_q  <= '0;
            tick_pend_q <= 1'b0;
            phase_q     <= '0;
        end else begin
            rate_acc_q  <= rate_acc_d;
            tick_pend_q <= tick_pend_d;
            phase_q     <= phase_d;
        end
    end

    // sample formation
    logic [PH_W-1:0] phase2;
    logic [23:0]     tone1, tone2;
    dtg_pair_type    pair_in;

    assign phase2 = PH_W'(phase_q + {phase_offset, 30'h0000_0000});
    assign tone1  = dtg_sine(phase_q[PH_W-1 -: TAB_BITS]);
    assign tone2  = dtg_sine(phase2[PH_W-1 -: TAB_BITS]);

    always_comb begin
        pair_in.first_sample  = first_gen_dc_select ? first_gen_dc_level_q : tone1;
        pair_in.second_sample = second_gen_dc_select ? second_gen_dc_level_q : tone2;
        if (!first_gen_enable) begin
            pair_in.first_sample = 24'h00_0000;
        end
        if (!second_gen_enable) begin
            pair_in.second_sample = 24'h00_0000;
        end
    end

    dtg_buf #(
        .WIDTH ($bits(dtg_pair_type)),
        .DEPTH (2)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (tick_pend_q),
        .in_ready  (push_ready),
        .in_data   (pair_in),
        .out_valid (pair_valid),
        .out_ready (pair_ready),
        .out_data  (pair_data)
    );

    // consumer pick, refreshed on each delivered pair
    logic [23:0] pick_q, pick_d;

    always_comb begin
        pick_d = pick_q;
        if (pair_valid && pair_ready) begin
            unique case (consumer_source_select)
                SRC_TONE1: pick_d = pair_data.first_sample;
                SRC_TONE2: pick_d = pair_data.second_sample;
                default:   pick_d = 24'h00_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pick_q <= 24'h00_0000;
        end else begin
            pick_q <= pick_d;
        end
    end

    assign consumer_sample = pick_q;

endmodule : dtg_top

// ===== inc/dtg_pkg.sv
// dual tone generator: register map, field layout, timing and sample types
// assumes a single core clock domain shared with the register port and consumers
package dtg_pkg;

    localparam int unsigned    CLK_HZ          = 20_000_000;
    localparam int unsigned    TONE_HZ         = 1_000;

    // register map
    localparam logic [15:0]    ADDR_CTRL       = 16'hB000;
    localparam logic [15:0]    ADDR_LVL1       = 16'hB004;
    localparam logic [15:0]    ADDR_LVL2       = 16'hB008;

    // control field positions
    localparam int unsigned    BIT_EN1         = 0;
    localparam int unsigned    BIT_EN2         = 1;
    localparam int unsigned    BIT_DC1         = 4;
    localparam int unsigned    BIT_DC2         = 5;
    localparam int unsigned    POS_OFFSET      = 8;
    localparam int unsigned    W_OFFSET        = 2;

    localparam logic [31:0]    CTRL_RESET      = 32'h0000_0000;
    localparam logic [23:0]    LVL_RESET       = 24'h10_0000;

    // consumer source codes, zero selects silence
    localparam logic [8:0]     SRC_NONE        = 9'h000;
    localparam logic [8:0]     SRC_TONE1       = 9'h004;
    localparam logic [8:0]     SRC_TONE2       = 9'h005;

    // phase accumulator
    localparam int unsigned    PH_W            = 32;
    localparam int unsigned    TAB_BITS        = 6;
    localparam int unsigned    RATE_W          = 18;
    localparam logic [RATE_W-1:0] RATE_RESET   = 18'h0BB80;

    typedef struct packed {
        logic [23:0] first_sample;
        logic [23:0] second_sample;
    } dtg_pair_type;

    // quarter-wave table, 16 steps per quadrant, 0x10_0000 is full scale
    function automatic logic [23:0] dtg_quarter(input logic [4:0] k);
        logic [23:0] v;
        v = 24'h00_0000;
        unique case (k)
            5'h00: v = 24'h00_0000;
            5'h01: v = 24'h01_917A;
            5'h02: v = 24'h03_1F17;
            5'h03: v = 24'h04_A501;
            5'h04: v = 24'h06_1F79;
            5'h05: v = 24'h07_8AD7;
            5'h06: v = 24'h08_E39D;
            5'h07: v = 24'h0A_2679;
            5'h08: v = 24'h0B_504F;
            5'h09: v = 24'h0C_5E40;
            5'h0A: v = 24'h0D_4DB3;
            5'h0B: v = 24'h0E_1C59;
            5'h0C: v = 24'h0E_C836;
            5'h0D: v = 24'h0F_4F9F;
            5'h0E: v = 24'h0F_B14C;
            5'h0F: v = 24'h0F_EC47;
            default: v = 24'h10_0000;
        endcase
        return v;
    endfunction : dtg_quarter

    // full sine from the top bits of a phase word
    function automatic logic [23:0] dtg_sine(input logic [TAB_BITS-1:0] p);
        logic [4:0]  k;
        logic [23:0] m;
        k = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
        m = dtg_quarter(k);
        return p[5] ? 24'(-m) : m;
    endfunction : dtg_sine

endpackage : dtg_pkg

// ===== tb/dtg_sink.sv
// stream consumer model: takes sample pairs, stalls on request
// assumes the same clk_sys domain as dtg_top
`timescale 1ns/1ps
module dtg_sink (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // stream
    input  wire logic                  pair_valid,
    output      logic                  pair_ready,
    input  wire dtg_pkg::dtg_pair_type pair_data,
    // bench side
    input  wire logic                  stall,
    output      logic [15:0]           n_taken,
    output      dtg_pkg::dtg_pair_type last_pair
);
    import dtg_pkg::*;
    // runs at the generator rate, so no rate conversion stage
    assign pair_ready = !stall;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_taken <= 16'h0000;
            last_pair <= '0;
        end else if (pair_valid && pair_ready) begin
            n_taken <= n_taken + 16'h0001;
            last_pair <= pair_data;
        end
    end
endmodule : dtg_sink

// ===== tb/dtg_sva.sv
// checker for the dtg_top stream, register readback and consumer port
// assumes binding into dtg_top, one clk_sys domain
`timescale 1ns/1ps
module dtg_sva (
    // clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    // register port
    input wire logic                  reg_rd_en,
    input wire logic [15:0]           reg_addr,
    input wire logic [31:0]           reg_rdata,
    // stream and consumer
    input wire logic                  pair_valid,
    input wire logic                  pair_ready,
    input wire dtg_pkg::dtg_pair_type pair_data,
    input wire logic [8:0]            consumer_source_select,
    input wire logic [23:0]           consumer_sample
);
    import dtg_pkg::*;
    logic        hs;
    logic [23:0] first_w;
    logic [23:0] second_w;
    assign hs = pair_valid && pair_ready;
    assign first_w = pair_data.first_sample;
    assign second_w = pair_data.second_sample;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_hold_valid; pair_valid && !pair_ready |=> pair_valid; endproperty
    a_hold_valid: assert property (p_hold_valid) else $error("pair dropped");
    property p_hold_data; pair_valid && !pair_ready |=> $stable(pair_data); endproperty
    a_hold_data: assert property (p_hold_data) else $error("pair changed");
    property p_src1;
        hs && consumer_source_select == SRC_TONE1 |=> consumer_sample == $past(first_w);
    endproperty
    a_src1: assert property (p_src1) else $error("first source wrong");
    property p_src2;
        hs && consumer_source_select == SRC_TONE2 |=> consumer_sample == $past(second_w);
    endproperty
    a_src2: assert property (p_src2) else $error("second source wrong");
    property p_none; hs && consumer_source_select == SRC_NONE |=> consumer_sample == 0;
    endproperty
    a_none: assert property (p_none) else $error("silence not zero");
    property p_ctrl; reg_rd_en && reg_addr == ADDR_CTRL |=> !(|(reg_rdata & 32'hFFFF_FCCC));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl spare bits set");
    property p_lvl;
        reg_rd_en && (reg_addr == ADDR_LVL1 || reg_addr == ADDR_LVL2) |=> reg_rdata[31:24] == 0;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level top byte set");
    property p_rhold; !reg_rd_en |=> $stable(reg_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    c_stall: cover property ((pair_valid && !pair_ready) [*3]);
    c_src2: cover property (hs && consumer_source_select == SRC_TONE2);
    c_ctrl: cover property (reg_rd_en && reg_addr == ADDR_CTRL);
endmodule : dtg_sva
bind dtg_top dtg_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .pair_valid(pair_valid),
    .pair_ready(pair_ready), .pair_data(pair_data),
    .consumer_source_select(consumer_source_select), .consumer_sample(consumer_sample));

// ===== tb/dtg_top_tb.sv
// bench for dtg_top: registers, dc and tone values, phase offsets, stall
// assumes dtg_sink as consumer; 64 kHz rate gives 64 samples per tone cycle
`timescale 1ns/1ps
module dtg_top_tb;
    import dtg_pkg::*;
    logic              clk_sys, rst_n, reg_wr_en, reg_rd_en, pair_valid, pair_ready, stall;
    logic [15:0]       reg_addr, n_taken;
    logic [31:0]       reg_wdata, reg_rdata;
    logic [RATE_W-1:0] tone_rate_hz;
    dtg_pair_type      pair_data, last_pair, p;
    logic [8:0]        consumer_source_select;
    logic [23:0]       consumer_sample;
    logic [23:0]       f1 [0:79];
    logic [23:0]       f2 [0:79];
    int                n_mismatch, checks_done, cyc;
    dtg_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .tone_rate_hz(tone_rate_hz), .pair_valid(pair_valid),
        .pair_ready(pair_ready), .pair_data(pair_data),
        .consumer_source_select(consumer_source_select), .consumer_sample(consumer_sample));
    dtg_sink sink_u (.clk_sys(clk_sys), .rst_n(rst_n), .pair_valid(pair_valid),
        .pair_ready(pair_ready), .pair_data(pair_data), .stall(stall),
        .n_taken(n_taken), .last_pair(last_pair));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic summarize;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // whole run needs about 70000 cycles
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        // idle edge so a following write never re-raises the strobe in this step
        @(negedge clk_sys);
    endtask : wr
    task automatic rdc(input string w, input logic [15:0] a, input logic [31:0] e);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        @(negedge clk_sys);
        chk(w, reg_rdata, e);
    endtask : rdc
    // skipped pairs flush what the buffer held before a change
    task automatic take(input int skip);
        logic [15:0] c;
        int          t;
        for (int i = 0; i <= skip; i++) begin
            c = n_taken;
            t = 0;
            while (n_taken === c && t < 1000) begin
                @(negedge clk_sys);
                t++;
            end
            if (t >= 1000) chk("pair arrival", 32'h0000_0000, 32'h0000_0001);
        end
        p = last_pair;
    endtask : take
    task automatic grab(input int n);
        take(3);
        for (int i = 0; i < n; i++) begin
            take(0);
            f1[i] = p.first_sample;
            f2[i] = p.second_sample;
        end
    endtask : grab
    task automatic t_regs;
        rdc("ctrl", ADDR_CTRL, CTRL_RESET);
        rdc("lvl1", ADDR_LVL1, 32'h0010_0000);
        rdc("lvl2", ADDR_LVL2, 32'h0010_0000);
        rdc("spare", 16'hB00C, 32'h0000_0000);
        wr(ADDR_CTRL, 32'hFFFF_FFFF);
        rdc("ctrl bits", ADDR_CTRL, 32'h0000_0333);
    endtask : t_regs
    task automatic t_dc;
        wr(ADDR_LVL1, 32'h00F0_0000);
        wr(ADDR_LVL2, 32'hFF12_3456);
        rdc("lvl2 wr", ADDR_LVL2, 32'h0012_3456);
        consumer_source_select = SRC_TONE2;
        wr(ADDR_CTRL, 32'h0000_0033);
        take(3);
        chk("dc1", p.first_sample, 24'hF0_0000);
        chk("dc2", p.second_sample, 24'h12_3456);
        chk("cons2", consumer_sample, 24'h12_3456);
        wr(ADDR_CTRL, 32'h0000_0011);
        take(3);
        chk("off2", p.second_sample, 24'h00_0000);
        chk("cons off2", consumer_sample, 24'h00_0000);
        consumer_source_select = SRC_TONE1;
        wr(ADDR_CTRL, 32'h0000_0032);
        take(3);
        chk("off1", p.first_sample, 24'h00_0000);
        chk("cons off1", consumer_sample, 24'h00_0000);
    endtask : t_dc
    task automatic t_tone;
        logic hi, lo;
        hi = 1'b0;
        lo = 1'b0;
        wr(ADDR_CTRL, 32'h0000_0003);
        grab(72);
        for (int i = 0; i < 64; i++) begin
            hi |= f1[i] === 24'h10_0000;
            lo |= f1[i] === 24'hF0_0000;
            if (i < 32) chk("half", f1[i+32], 24'(-f1[i]));
            if (i < 8) chk("period", f1[i+64], f1[i]);
            chk("lag0", f2[i], f1[i]);
        end
        chk("peaks", {hi, lo}, 2'b11);
        for (int k = 1; k < 4; k++) begin
            wr(ADDR_CTRL, 32'h0000_0003 | 32'(k << 8));
            grab(36);
            for (int i = 0; i < 4; i++) begin
                if (k == 3) chk("lead", f2[i+16], f1[i]);
                else chk("lead", f2[i], f1[i+16*k]);
            end
        end
    endtask : t_tone
    task automatic t_stall;
        logic [15:0] c;
        stall = 1'b1;
        repeat (2000) @(negedge clk_sys);
        chk("held", pair_valid, 1'b1);
        c = n_taken;
        stall = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk("no loss", 16'(n_taken - c) inside {16'h3, 16'h4}, 1'b1);
        // zero rate: after the last pending pair drains, no sample is made
        tone_rate_hz = 18'h00000;
        repeat (400) @(negedge clk_sys);
        c = n_taken;
        repeat (1000) @(negedge clk_sys);
        chk("rate zero", n_taken, c);
    endtask : t_stall
    initial begin
        rst_n = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0000_0000;
        tone_rate_hz = 18'h0FA00;
        stall = 1'b0;
        consumer_source_select = SRC_NONE;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        t_regs();
        t_dc();
        t_tone();
        t_stall();
        summarize();
    end
endmodule : dtg_top_tb
